// [prl_guard.sv]
// Purpose: lock guard and mux control for remappable pins
// Assumes: APB slave, MCLK 10 MHz, NRST async active low
// Notes: answers every transfer in its first access cycle
`timescale 1ns/1ps
`default_nettype none
module prl_guard (
  input wire logic MCLK, // system clock
  input wire logic NRST, // async reset, active low
  input wire logic CE, // clock enable, freezes state when low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb direction
  input wire logic [11:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  input wire logic [3:0] PSTRB, // apb byte strobes
  output logic PREADY, // apb ready
  output logic [31:0] PRDATA, // apb read data
  output logic PSLVERR, // apb error, unmapped address
  input wire logic SINGLE_SESSION_LOCK_FUSE, // config word fuse level
  input wire logic [25:0] PIN_IN, // pad input levels
  input wire logic [25:0] PORT_OUT, // default port output data
  input wire logic [25:0] PIN_DIRECTION, // direction, 1 is input
  input wire logic [31:0] PERIPH_OUT, // peripheral outputs by select code
  output logic [25:0] PIN_OUT, // pad output data
  output logic [25:0] PIN_OE, // pad output enable, high drives
  output logic [25:0] PIN_DIGITAL, // digital read of each pin
  output logic [39:0] PERIPH_IN, // routed peripheral inputs
  output logic MAPPING_WRITE_LOCK, // current lock state
  output logic CONFIG_MISMATCH_RESET // shadow mismatch reset request
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [26:0] sync1;
  logic [26:0] sync2;
  logic [26:0] sync3;
  logic [26:0] stable;
  wire [26:0] raw_in = {SINGLE_SESSION_LOCK_FUSE, PIN_IN};
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sync1 <= 27'h4000000;
      sync2 <= 27'h4000000;
      sync3 <= 27'h4000000;
    end else if (CE) begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  // fuse reset high so one-session protection holds from the start
  genvar g;
  generate
    for (g = 0; g < 27; g++) begin : g_stable
      always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
          stable[g] <= (g == 26) ? 1'b1 : 1'b0;
        end else if (CE && (sync2[g] == sync3[g])) begin
          stable[g] <= sync3[g];
        end
      end
    end
  endgenerate
  wire fuse_one_way = stable[26];
  wire [25:0] pin_level = stable[25:0];
  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic lock;
  prl_pkg::prl_key_t key_state;
  logic [15:0] in_map [0:prl_pkg::NUM_IN_REGS-1];
  logic [15:0] in_shadow [0:prl_pkg::NUM_IN_REGS-1];
  logic [15:0] out_map [0:prl_pkg::NUM_OUT_REGS-1];
  logic [15:0] out_shadow [0:prl_pkg::NUM_OUT_REGS-1];
  logic [15:0] analog_cfg_low;
  logic [15:0] analog_cfg_high;
  wire setup = PSEL && !PENABLE && !PREADY;
  wire access_done = PSEL && PENABLE && PREADY;
  wire wr = access_done && PWRITE;
  wire low_lane = PSTRB[0];
  wire [11:0] in_off = PADDR - prl_pkg::OFS_IN_MAP_BASE;
  wire [11:0] out_off = PADDR - prl_pkg::OFS_OUT_MAP_BASE;
  wire [9:0] in_idx = in_off[11:2];
  wire [9:0] out_idx = out_off[11:2];
  wire hit_in = (PADDR >= prl_pkg::OFS_IN_MAP_BASE) && (in_idx < 10'(prl_pkg::NUM_IN_REGS))
    && (PADDR[1:0] == 2'h0);
  wire hit_out = (PADDR >= prl_pkg::OFS_OUT_MAP_BASE) && (out_idx < 10'(prl_pkg::NUM_OUT_REGS))
    && (PADDR[1:0] == 2'h0);
  wire hit_osc = PADDR == prl_pkg::OFS_OSC_CTRL;
  wire hit_alow = PADDR == prl_pkg::OFS_ANALOG_CFG_LOW;
  wire hit_ahigh = PADDR == prl_pkg::OFS_ANALOG_CFG_HIGH;
  wire hit_pins = PADDR == prl_pkg::OFS_PIN_STATE;
  wire hit_status = PADDR == prl_pkg::OFS_GUARD_STATUS;
  wire hit_any = hit_in || hit_out || hit_osc || hit_alow || hit_ahigh || hit_pins || hit_status;
  wire [4:0] in_sel = in_idx[4:0];
  wire [3:0] out_sel = out_idx[3:0];
  // ------------------------------------------------------------
  // key sequence and lock
  // ------------------------------------------------------------
  wire osc_wr = wr && hit_osc && low_lane;
  wire key1 = osc_wr && (PWDATA[7:0] == prl_pkg::KEY_FIRST);
  wire key2 = osc_wr && (PWDATA[7:0] == prl_pkg::KEY_SECOND);
  wire frozen = fuse_one_way && lock;
  wire lock_update = osc_wr && (key_state == prl_pkg::KEY_ARMED) && !frozen;
  prl_pkg::prl_key_t next_key_state;
  always_comb begin
    next_key_state = key_state;
    if (wr) begin
      case (key_state)
        prl_pkg::KEY_IDLE: next_key_state = (key1 && !frozen) ? prl_pkg::KEY_GOT_FIRST : prl_pkg::KEY_IDLE;
        prl_pkg::KEY_GOT_FIRST: next_key_state = key2 ? prl_pkg::KEY_ARMED : prl_pkg::KEY_IDLE;
        prl_pkg::KEY_ARMED: next_key_state = prl_pkg::KEY_IDLE;
        default: next_key_state = prl_pkg::KEY_IDLE;
      endcase
    end
  end
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      key_state <= prl_pkg::KEY_IDLE;
      lock <= 1'b0;
    end else if (CE) begin
      key_state <= next_key_state;
      if (lock_update) begin
        lock <= PWDATA[prl_pkg::LOCK_BIT];
      end
    end
  end
  // ------------------------------------------------------------
  // mapping registers and shadows
  // ------------------------------------------------------------
  wire map_wr_ok = wr && !lock;
  wire [15:0] in_wdata = PWDATA[15:0] &
    ((in_sel == 5'h0) ? prl_pkg::IN_MAP0_MASK : prl_pkg::MAP_MASK);
  wire [15:0] out_wdata = PWDATA[15:0] & prl_pkg::MAP_MASK;
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < prl_pkg::NUM_IN_REGS; i++) begin
        in_map[i] <= (i == 0) ? prl_pkg::IN_MAP0_RESET : prl_pkg::IN_MAP_RESET;
        in_shadow[i] <= (i == 0) ? prl_pkg::IN_MAP0_RESET : prl_pkg::IN_MAP_RESET;
      end
      for (int i = 0; i < prl_pkg::NUM_OUT_REGS; i++) begin
        out_map[i] <= prl_pkg::OUT_MAP_RESET;
        out_shadow[i] <= prl_pkg::OUT_MAP_RESET;
      end
    end else if (CE) begin
      if (map_wr_ok && hit_in) begin
        in_map[in_sel] <= in_wdata;
        in_shadow[in_sel] <= in_wdata;
      end
      if (map_wr_ok && hit_out) begin
        out_map[out_sel] <= out_wdata;
        out_shadow[out_sel] <= out_wdata;
      end
    end
  end
  logic mismatch;
  always_comb begin
    mismatch = 1'b0;
    for (int i = 0; i < prl_pkg::NUM_IN_REGS; i++) begin
      mismatch = mismatch | (in_map[i] != in_shadow[i]);
    end
    for (int i = 0; i < prl_pkg::NUM_OUT_REGS; i++) begin
      mismatch = mismatch | (out_map[i] != out_shadow[i]);
    end
  end
  // ------------------------------------------------------------
  // analog configuration
  // ------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      analog_cfg_low <= prl_pkg::ANALOG_CFG_RESET;
      analog_cfg_high <= prl_pkg::ANALOG_CFG_RESET;
    end else if (CE) begin
      if (wr && hit_alow) begin
        analog_cfg_low <= PWDATA[15:0];
      end
      if (wr && hit_ahigh) begin
        analog_cfg_high <= PWDATA[15:0];
      end
    end
  end
  logic [25:0] is_analog;
  logic [25:0] digital_level;
  always_comb begin
    for (int i = 0; i < prl_pkg::NUM_PINS; i++) begin
      if (i < prl_pkg::ANALOG_BITS) begin
        is_analog[i] = prl_pkg::ANALOG_SHARED[i] && !(analog_cfg_low[i] && analog_cfg_high[i]);
      end else begin
        is_analog[i] = prl_pkg::ANALOG_SHARED[i];
      end
      digital_level[i] = pin_level[i] && !is_analog[i];
    end
  end
  // ------------------------------------------------------------
  // input routing
  // ------------------------------------------------------------
  logic [39:0] next_periph_in;
  always_comb begin
    logic [4:0] sel;
    sel = 5'h0;
    next_periph_in = '0;
    for (int k = 0; k < prl_pkg::NUM_PERIPH_IN; k++) begin
      sel = (k % 2 == 1) ? in_map[k / 2][prl_pkg::FIELD_HI_LSB +: 5] : in_map[k / 2][prl_pkg::FIELD_LO_LSB +: 5];
      if (sel == prl_pkg::SEL_TIE_LOW || sel > prl_pkg::SEL_MAX_PIN) begin
        next_periph_in[k] = 1'b0;
      end else begin
        next_periph_in[k] = digital_level[sel];
      end
    end
  end
  // ------------------------------------------------------------
  // output routing and pin priority
  // ------------------------------------------------------------
  logic [25:0] next_pin_out;
  logic [25:0] next_pin_oe;
  always_comb begin
    logic [4:0] osel;
    osel = 5'h0;
    for (int p = 0; p < prl_pkg::NUM_PINS; p++) begin
      osel = (p % 2 == 1) ? out_map[p / 2][prl_pkg::FIELD_HI_LSB +: 5] : out_map[p / 2][prl_pkg::FIELD_LO_LSB +: 5];
      if (is_analog[p]) begin
        next_pin_out[p] = 1'b0;
        next_pin_oe[p] = 1'b0;
      end else if (osel != prl_pkg::SEL_NULL) begin
        next_pin_out[p] = PERIPH_OUT[osel];
        next_pin_oe[p] = !PIN_DIRECTION[p];
      end else begin
        next_pin_out[p] = PORT_OUT[p];
        next_pin_oe[p] = !PIN_DIRECTION[p];
      end
    end
  end
  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  wire [31:0] osc_rd = {25'h0, lock, fuse_one_way, 3'h0, key_state};
  wire [31:0] status_rd = {30'h0, mismatch, lock};
  wire [31:0] rd_data = hit_in ? {16'h0, in_map[in_sel]} :
    hit_out ? {16'h0, out_map[out_sel]} :
    hit_osc ? osc_rd :
    hit_alow ? {16'h0, analog_cfg_low} :
    hit_ahigh ? {16'h0, analog_cfg_high} :
    hit_pins ? {6'h0, digital_level} :
    hit_status ? status_rd : 32'h0;
  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY <= setup;
      PSLVERR <= setup && !hit_any;
      PRDATA <= (setup && !PWRITE) ? rd_data : 32'h0;
    end
  end
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      PIN_OUT <= '0;
      PIN_OE <= '0;
      PIN_DIGITAL <= '0;
      PERIPH_IN <= '0;
      MAPPING_WRITE_LOCK <= 1'b0;
      CONFIG_MISMATCH_RESET <= 1'b0;
    end else if (CE) begin
      PIN_OUT <= next_pin_out;
      PIN_OE <= next_pin_oe;
      PIN_DIGITAL <= digital_level;
      PERIPH_IN <= next_periph_in;
      MAPPING_WRITE_LOCK <= lock;
      CONFIG_MISMATCH_RESET <= mismatch;
    end
  end
endmodule
`default_nettype wire

// [prl_pkg.sv]
// Purpose: constants for the pin remap lock guard
// Assumes: APB register map, 32-bit aligned words
// Notes: offsets in bytes
package prl_pkg;
  localparam int NUM_PINS = 26;
  localparam int NUM_IN_REGS = 20;
  localparam int NUM_OUT_REGS = 13;
  localparam int NUM_PERIPH_IN = 40;
  localparam int NUM_PERIPH_OUT = 32;
  localparam int ANALOG_BITS = 16;
  // --------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------
  localparam logic [11:0] OFS_OSC_CTRL = 12'h000;
  localparam logic [11:0] OFS_ANALOG_CFG_LOW = 12'h004;
  localparam logic [11:0] OFS_ANALOG_CFG_HIGH = 12'h008;
  localparam logic [11:0] OFS_PIN_STATE = 12'h00c;
  localparam logic [11:0] OFS_GUARD_STATUS = 12'h010;
  localparam logic [11:0] OFS_IN_MAP_BASE = 12'h100;
  localparam logic [11:0] OFS_OUT_MAP_BASE = 12'h200;
  // --------------------------------------------------------------
  // fields
  // --------------------------------------------------------------
  localparam int LOCK_BIT = 6;
  localparam int FUSE_BIT = 5;
  localparam int FIELD_HI_LSB = 8;
  localparam int FIELD_LO_LSB = 0;
  localparam logic [7:0] KEY_FIRST = 8'h46;
  localparam logic [7:0] KEY_SECOND = 8'h57;
  localparam logic [4:0] SEL_TIE_LOW = 5'h1f;
  localparam logic [4:0] SEL_MAX_PIN = 5'h19;
  localparam logic [4:0] SEL_NULL = 5'h00;
  localparam logic [15:0] IN_MAP0_MASK = 16'h1f00;
  localparam logic [15:0] MAP_MASK = 16'h1f1f;
  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [15:0] IN_MAP0_RESET = 16'h1f00;
  localparam logic [15:0] IN_MAP_RESET = 16'h1f1f;
  localparam logic [15:0] OUT_MAP_RESET = 16'h0000;
  localparam logic [15:0] ANALOG_CFG_RESET = 16'h0000;
  localparam logic [NUM_PINS-1:0] ANALOG_SHARED = 26'h00001ff;
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} prl_key_t;
endpackage

// [prl_guard_props.sv]
// Purpose: port checks for the pin remap lock guard
// Assumes: CE held high, key steps sent back to back
// Notes: bound to every prl_guard instance
`timescale 1ns/1ps
`default_nettype none
module prl_guard_props (
  input wire logic MCLK, // clock
  input wire logic NRST, // async reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb direction
  input wire logic [11:0] PADDR, // apb address
  input wire logic [31:0] PWDATA, // apb write data
  input wire logic [3:0] PSTRB, // apb strobes
  input wire logic PREADY, // apb ready
  input wire logic [31:0] PRDATA, // apb read data
  input wire logic PSLVERR, // apb error
  input wire logic SINGLE_SESSION_LOCK_FUSE, // fuse level
  input wire logic MAPPING_WRITE_LOCK, // lock state
  input wire logic CONFIG_MISMATCH_RESET // mismatch reset
);
  logic [3:0] fuse_hi;
  wire osc_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == prl_pkg::OFS_OSC_CTRL && PSTRB[0];
  wire in_rng = PADDR >= prl_pkg::OFS_IN_MAP_BASE && PADDR < 12'h150;
  wire out_rng = PADDR >= prl_pkg::OFS_OUT_MAP_BASE && PADDR < 12'h234;
  wire mapped = PADDR[1:0] == 2'h0 && (PADDR <= prl_pkg::OFS_GUARD_STATUS || in_rng || out_rng);
  // cycles the fuse has stood high
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) fuse_hi <= 4'h0;
    else fuse_hi <= SINGLE_SESSION_LOCK_FUSE ? fuse_hi + {3'h0, fuse_hi != 4'hf} : 4'h0;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  sequence key_wr(logic [7:0] v);
    osc_wr && PWDATA[7:0] == v;
  endsequence
  sequence set_lock;
    key_wr(prl_pkg::KEY_FIRST) ##2 key_wr(prl_pkg::KEY_SECOND) ##2 (osc_wr && PWDATA[6]);
  endsequence
  a_ready_first_access: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready in first access cycle");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (PSEL && !PENABLE && !mapped |=> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  a_map_no_error: assert property (PSEL && !PENABLE && mapped |=> !PSLVERR)
    else $error("error on a mapped register");
  a_idle_data_zero: assert property (!PREADY |-> PRDATA == 32'h0 && !PSLVERR)
    else $error("read data outside an answer");
  a_lock_by_write: assert property ((!osc_wr ##1 !osc_wr) |=> $stable(MAPPING_WRITE_LOCK))
    else $error("lock moved without a control write");
  a_key_sets_lock: assert property (set_lock |-> ##2 MAPPING_WRITE_LOCK)
    else $error("keyed set left lock clear");
  a_fuse_holds_lock: assert property (MAPPING_WRITE_LOCK && fuse_hi > 4'h5 |=> MAPPING_WRITE_LOCK)
    else $error("lock cleared under fuse");
  a_no_mismatch: assert property (!CONFIG_MISMATCH_RESET)
    else $error("mismatch reset without disturbance");
endmodule
bind prl_guard prl_guard_props prl_guard_props_inst (.MCLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PSTRB, .PREADY, .PRDATA, .PSLVERR, .SINGLE_SESSION_LOCK_FUSE, .MAPPING_WRITE_LOCK,
  .CONFIG_MISMATCH_RESET);
`default_nettype wire

// [tb_pin_remap_lock_guard.sv]
// Purpose: self-checking bench for the pin remap lock guard
// Assumes: zero-wait apb slave, CE held high
// Notes: random data from a 16-bit lfsr
`timescale 1ns/1ps
`default_nettype none
module tb_pin_remap_lock_guard;
  logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fuse = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, periph_out = 32'h0, prdata, rd, d, e, m0;
  logic [25:0] pin_in = 26'h3ffffff, port_out = 26'h0, pin_out, pin_digital;
  logic [39:0] periph_in;
  logic [15:0] lfsr = 16'd26291;
  logic pready, pslverr, lock, mism;
  logic [11:0] ra [6] = '{12'h100, 12'h14c, 12'h230, 12'h150, 12'h234, 12'h014};
  logic [31:0] rv [3] = '{32'h1f00, 32'h1f1f, 32'h0};
  int err_count = 0;
  int check_count = 0;
  int i;
  always #50 mclk = ~mclk;
  // pin 10 output, mapped inputs set to input
  prl_guard prl_guard_inst (.MCLK(mclk), .NRST(nrst), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .SINGLE_SESSION_LOCK_FUSE(fuse), .PIN_IN(pin_in), .PORT_OUT(port_out),
    .PIN_DIRECTION(26'h3fffbff), .PERIPH_OUT(periph_out), .PIN_OUT(pin_out), .PIN_OE(),
    .PIN_DIGITAL(pin_digital), .PERIPH_IN(periph_in), .MAPPING_WRITE_LOCK(lock),
    .CONFIG_MISMATCH_RESET(mism));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd, input logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    chk_word("answer", {30'h0, 1'b1, err}, {30'h0, pready, pslverr});
  endtask
  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic key(input logic v, input logic brk);
    apb(1'b1, prl_pkg::OFS_OSC_CTRL, {24'h0, prl_pkg::KEY_FIRST}, 1'b0);
    if (brk) apb(1'b1, prl_pkg::OFS_IN_MAP_BASE, 32'h0, 1'b0);
    apb(1'b1, prl_pkg::OFS_OSC_CTRL, {24'h0, prl_pkg::KEY_SECOND}, 1'b0);
    apb(1'b1, prl_pkg::OFS_OSC_CTRL, {25'h0, v, 6'h0}, 1'b0);
    repeat (2) idle();
  endtask
  task automatic do_reset;
    nrst <= 1'b0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask
  task automatic print_verdict;
    $display("checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    print_verdict();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    do_reset();
    for (i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0, i > 2);
      chk_word("reset read", (i > 2) ? 32'h0 : rv[i], rd);
    end
    apb(1'b0, prl_pkg::OFS_OSC_CTRL, 32'h0, 1'b0);
    chk_word("control", 32'h0, rd);
    chk_word("digital", {6'h0, ~prl_pkg::ANALOG_SHARED}, {6'h0, pin_digital});
    apb(1'b1, prl_pkg::OFS_ANALOG_CFG_LOW, 32'h8, 1'b0);
    repeat (2) idle();
    chk_bit("pin3 digital", 1'b0, pin_digital[3]);
    apb(1'b1, prl_pkg::OFS_ANALOG_CFG_HIGH, 32'h8, 1'b0);
    repeat (2) idle();
    chk_bit("pin3 digital", 1'b1, pin_digital[3]);
    for (i = 0; i < 8; i++) begin
      lfsr = lfsr_step(lfsr);
      d = {16'h0, lfsr | 16'h1000};
      if (i < 2) d[12:8] = i ? prl_pkg::SEL_TIE_LOW : prl_pkg::SEL_MAX_PIN;
      pin_in <= {lfsr[9:0], lfsr};
      apb(1'b1, prl_pkg::OFS_IN_MAP_BASE, d, 1'b0);
      repeat (6) idle();
      e = (d[12:8] <= prl_pkg::SEL_MAX_PIN) ? {31'h0, pin_in[d[12:8]]} : 32'h0;
      chk_word("irq1 input", e, {31'h0, periph_in[1]});
      apb(1'b0, prl_pkg::OFS_IN_MAP_BASE, 32'h0, 1'b0);
      m0 = d & 32'h1f00;
      chk_word("in map0", m0, rd);
    end
    for (i = 0; i < 4; i++) begin
      lfsr = lfsr_step(lfsr);
      port_out <= {lfsr[9:0], lfsr};
      periph_out <= {lfsr, ~lfsr};
      d = (i == 0) ? 32'h0 : {27'h0, lfsr[4:0]};
      apb(1'b1, prl_pkg::OFS_OUT_MAP_BASE + 12'h014, d, 1'b0);
      repeat (2) idle();
      e = (d[4:0] == 5'h0) ? {31'h0, port_out[10]} : {31'h0, periph_out[d[4:0]]};
      chk_word("pin10 out", e, {31'h0, pin_out[10]});
    end
    key(1'b1, 1'b0);
    chk_bit("lock", 1'b1, lock);
    apb(1'b0, prl_pkg::OFS_OSC_CTRL, 32'h0, 1'b0);
    chk_word("control", 32'h40, rd);
    apb(1'b1, prl_pkg::OFS_IN_MAP_BASE, 32'h0, 1'b0);
    apb(1'b0, prl_pkg::OFS_IN_MAP_BASE, 32'h0, 1'b0);
    chk_word("locked map", m0, rd);
    key(1'b0, 1'b1);
    chk_bit("lock", 1'b1, lock);
    key(1'b0, 1'b0);
    chk_bit("lock", 1'b0, lock);
    fuse <= 1'b1;
    repeat (6) idle();
    key(1'b1, 1'b0);
    key(1'b0, 1'b0);
    chk_bit("lock", 1'b1, lock);
    apb(1'b1, prl_pkg::OFS_IN_MAP_BASE, 32'h0, 1'b0);
    apb(1'b0, prl_pkg::OFS_IN_MAP_BASE, 32'h0, 1'b0);
    chk_word("locked map", m0, rd);
    idle();
    do_reset();
    chk_bit("lock", 1'b0, lock);
    apb(1'b0, prl_pkg::OFS_OSC_CTRL, 32'h0, 1'b0);
    chk_word("control", 32'h20, rd);
    idle();
    print_verdict();
  end
endmodule
`default_nettype wire
